//--- usbsie_pkg.sv
`default_nettype none
package usbsie_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_TIMING_IRQ = 8'h00;
   localparam logic [7:0] OFS_TIMING_STATUS = 8'h04;
   localparam logic [7:0] OFS_HUB_ADDR = 8'h08;
   localparam logic [7:0] OFS_EP0_IRQ = 8'h0C;
   localparam logic [7:0] OFS_EP0_CTRL = 8'h10;
   // timing interrupt register fields
   localparam int B_SOF_F = 7;
   localparam int B_FRAME_END_POINT_F = 6;
   localparam int B_EOP_F = 5;
   localparam int B_TRAN_F = 4;
   localparam int B_SOF_IE = 3;
   localparam int B_FRAME_END_POINT_IE = 2;
   localparam int B_EOP_IE = 1;
   localparam int B_TRAN_IE = 0;
   // timing status register fields
   localparam int B_RST_F = 7;
   localparam int B_RST_CLR = 6;
   localparam int B_LOCK_F = 5;
   localparam int B_LOCK_CLR = 4;
   localparam int B_SOF_CLR = 3;
   localparam int B_FRAME_END_POINT_CLR = 2;
   localparam int B_EOP_CLR = 1;
   localparam int B_TRAN_CLR = 0;
   // hub address register fields
   localparam int B_MOD_EN = 7;
   localparam int ADDR_W = 7;
   // endpoint 0 interrupt register fields
   localparam int B_TX_F = 7;
   localparam int B_RX_F = 6;
   localparam int B_TX_IE = 3;
   localparam int B_RX_IE = 2;
   localparam int B_TX_CLR = 1;
   localparam int B_RX_CLR = 0;
   // endpoint 0 control register fields
   localparam int B_EP0_TX_DATA_TOGGLE = 7;
   localparam int B_STALL = 6;
   localparam int B_TXE = 5;
   localparam int B_RXE = 4;
   localparam int TSIZE_W = 4;
   localparam logic [3:0] EP0 = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int FRAME_NS = 1000000;
   localparam int FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS;
   localparam int BIT_TIME_PS = 83333;
   localparam int FRAME_END_POINT_BITS = 10;
   localparam int FRAME_END_POINT_CYCLES =
      (FRAME_END_POINT_BITS * BIT_TIME_PS) / (CLK_PERIOD_NS * 1000);
   localparam int BUS_RESET_NS = 2500;
   localparam int BUS_RESET_CYCLES =
      (BUS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_TOL_CYCLES = 8;
   localparam int LOCK_FRAMES = 2;
   typedef enum logic [1:0] {PID_OUT, PID_IN, PID_SETUP, PID_SOF}
      usbsie_pid_type;
   typedef enum logic [2:0] {HS_ACK, HS_NAK, HS_STALL, HS_DATA0, HS_DATA1}
      usbsie_hs_type;
endpackage
`default_nettype wire

//--- usbsie_frame_timer.sv
`default_nettype none
module usbsie_frame_timer import usbsie_pkg::*; #(
   parameter int FRAME_LEN = FRAME_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sof_seen,
   output logic frame_end_point_pulse,
   output logic lock_pulse
);
   if (FRAME_LEN <= FRAME_END_POINT_CYCLES + LOCK_TOL_CYCLES)
      $error("frame length too short");
   logic [31:0] cnt_q;
   logic [1:0] good_q;
   logic near_end;
   assign near_end = cnt_q >= 32'(FRAME_LEN - 1 - LOCK_TOL_CYCLES);
   // free runs between frames so the end point still fires if a frame is lost
   always_ff @(posedge aclk) begin
      if (!aresetn || sof_seen || cnt_q == 32'(FRAME_LEN - 1)) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_end_point_pulse <= 1'b0;
      end else begin
         frame_end_point_pulse <= cnt_q == 32'(FRAME_LEN - FRAME_END_POINT_CYCLES);
      end
   end
   // lock after consecutive start-of-frames arriving where expected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         good_q <= '0;
         lock_pulse <= 1'b0;
      end else begin
         lock_pulse <= 1'b0;
         if (sof_seen) begin
            if (!near_end) begin
               good_q <= '0;
            end else if (good_q == 2'(LOCK_FRAMES - 1)) begin
               lock_pulse <= 1'b1;
            end else begin
               good_q <= good_q + 2'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- usbsie_line_monitor.sv
`default_nettype none
module usbsie_line_monitor import usbsie_pkg::*; #(
   parameter int RESET_LEN = BUS_RESET_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic root_dp,
   input wire logic root_dm,
   input wire logic downstream_activity,
   output logic transition_pulse,
   output logic eop_pulse,
   output logic bus_reset_pulse
);
   if (RESET_LEN < 2 || RESET_LEN > 65535)
      $error("bus reset length out of range");
   logic [1:0] prev_q;
   logic [15:0] se0_cnt_q;
   logic se0;
   assign se0 = !root_dp && !root_dm;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= {root_dp, root_dm};
         transition_pulse <= 1'b0;
         eop_pulse <= 1'b0;
      end else begin
         prev_q <= {root_dp, root_dm};
         transition_pulse <= downstream_activity
            || prev_q != {root_dp, root_dm};
         // single-ended zero followed by idle J ends a packet
         eop_pulse <= prev_q == 2'b00 && root_dp && !root_dm;
      end
   end
   // long single-ended zero is a bus reset; reported once per episode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         se0_cnt_q <= '0;
         bus_reset_pulse <= 1'b0;
      end else begin
         bus_reset_pulse <= se0 && se0_cnt_q == 16'(RESET_LEN - 1);
         if (!se0) begin
            se0_cnt_q <= '0;
         end else if (se0_cnt_q != 16'(RESET_LEN)) begin
            se0_cnt_q <= se0_cnt_q + 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- usbsie_core.sv
// How it works
// - flag the frame end point ten bit times before the next frame start.
// - flag each valid end of packet on the root port; clear strobe clears it.
// - flag any line transition upstream or downstream, for wakeup.
// - four timing interrupt enables gate their flags; reset clears them.
// - bus reset on the root port sets a flag and pulses system reset.
// - bus reset flag cleared only by power-on or its clear strobe.
// - flag frame timer lock to host frames; clear strobe clears it.
// - clear strobes act on one, ignore zero, and read back as zero.
// - module disabled ignores tokens, supply output and transceiver off.
// - module enable once set cannot be cleared by software.
// - seven-bit hub address, reset to zero, selects tokens for the hub.
// - transmit flag set after data sent and host acknowledged.
// - with transmit flag set, next IN gets negative acknowledge.
// - receive flag set after data accepted and acknowledged.
// - with receive flag set, next OUT gets negative acknowledge.
// - endpoint transmit and receive interrupt enables, cleared by reset.
// - software picks DATA0 or DATA1; hardware never toggles it.
// - stall answers IN and OUT with STALL; SETUP clears stall.
// - IN gets negative acknowledge if transmit disabled or flag set.
// - flag each valid start-of-frame; clear strobe clears it.
// - OUT gets negative acknowledge if receive disabled or flag set.
`default_nettype none
module usbsie_core import usbsie_pkg::*; #(
   parameter int FRAME_LEN = FRAME_CYCLES,
   parameter int RESET_LEN = BUS_RESET_CYCLES
) (
   // clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic por_n,
   // register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // root port line state and downstream activity
   input wire logic root_dp,
   input wire logic root_dm,
   input wire logic downstream_activity,
   // decoded tokens from the packet receiver
   input wire logic tok_valid,
   input wire usbsie_pid_type tok_pid,
   input wire logic [6:0] tok_addr,
   input wire logic [3:0] tok_endp,
   // packet events
   input wire logic rx_data_ok,
   input wire logic host_ack,
   // handshake / data packet request to the transmitter
   output logic hs_valid,
   output usbsie_hs_type hs_code,
   output logic [3:0] hs_tx_size,
   // system side
   output logic irq,
   output logic bus_reset_req,
   output logic regulated_supply_output,
   output logic transceiver_enable
);
   typedef enum {ST_IDLE, ST_WAIT_ACK, ST_WAIT_DATA} usbsie_state_type;

   // set wins over a clear in the same cycle
   function automatic logic flag_next(input logic cur, input logic set,
                                      input logic clr);
      return set || (cur && !clr);
   endfunction

   logic frame_end_point_pulse, lock_pulse;
   logic transition_pulse, eop_pulse, bus_reset_pulse;
   logic sof_seen;

   // timing flags and enables
   logic frame_start_flag_q, frame_end_point_flag_q;
   logic packet_end_flag_q, bus_activity_flag_q;
   logic frame_start_irq_enable_q, frame_end_point_irq_enable_q;
   logic packet_end_irq_enable_q, bus_activity_irq_enable_q;
   logic bus_reset_flag_q, frame_lock_flag_q;
   // address and enable
   logic module_enable_q;
   logic [ADDR_W-1:0] hub_function_addr_q;
   // endpoint 0
   logic ep0_tx_done_flag_q, ep0_rx_done_flag_q;
   logic ep0_tx_irq_enable_q, ep0_rx_irq_enable_q;
   logic ep0_tx_data_toggle_q, ep0_force_stall_q;
   logic ep0_tx_enable_q, ep0_rx_enable_q;
   logic [TSIZE_W-1:0] ep0_tx_size_q;
   usbsie_state_type state_q;

   // bus write decode
   logic wr_fire, rd_fire;
   logic [7:0] wbyte;
   logic wr_ti, wr_ts, wr_ha, wr_ei, wr_ec;
   logic wr_mapped;

   usbsie_frame_timer #(
      .FRAME_LEN(FRAME_LEN)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .sof_seen(sof_seen),
      .frame_end_point_pulse(frame_end_point_pulse),
      .lock_pulse(lock_pulse)
   );

   usbsie_line_monitor #(
      .RESET_LEN(RESET_LEN)
   ) u_lines (
      .aclk(aclk),
      .aresetn(aresetn),
      .root_dp(root_dp),
      .root_dm(root_dm),
      .downstream_activity(downstream_activity),
      .transition_pulse(transition_pulse),
      .eop_pulse(eop_pulse),
      .bus_reset_pulse(bus_reset_pulse)
   );

   // tokens only count while enabled; SOF is broadcast, others need address
   logic tok_live, tok_ep0;
   assign tok_live = tok_valid && module_enable_q;
   assign sof_seen = tok_live && tok_pid == PID_SOF;
   assign tok_ep0 = tok_live && tok_pid != PID_SOF
      && tok_addr == hub_function_addr_q && tok_endp == EP0;

   // ---------------- register bus ----------------
   assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
   assign rd_fire = s_axi_arready && s_axi_arvalid;
   // only the low byte lane holds register bits
   assign wbyte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
   assign wr_ti = wr_fire && s_axi_awaddr == OFS_TIMING_IRQ && s_axi_wstrb[0];
   assign wr_ts = wr_fire && s_axi_awaddr == OFS_TIMING_STATUS
      && s_axi_wstrb[0];
   assign wr_ha = wr_fire && s_axi_awaddr == OFS_HUB_ADDR && s_axi_wstrb[0];
   assign wr_ei = wr_fire && s_axi_awaddr == OFS_EP0_IRQ && s_axi_wstrb[0];
   assign wr_ec = wr_fire && s_axi_awaddr == OFS_EP0_CTRL && s_axi_wstrb[0];
   assign wr_mapped = s_axi_awaddr == OFS_TIMING_IRQ
      || s_axi_awaddr == OFS_TIMING_STATUS || s_axi_awaddr == OFS_HUB_ADDR
      || s_axi_awaddr == OFS_EP0_IRQ || s_axi_awaddr == OFS_EP0_CTRL;

   // both channels taken together, one write in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid
            && !s_axi_bvalid;
         s_axi_wready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid
            && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      end
   end

   // clear strobe bits have no storage, so they always read back zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
         unique case (s_axi_araddr)
            OFS_TIMING_IRQ: s_axi_rdata[7:0] <= {frame_start_flag_q,
               frame_end_point_flag_q, packet_end_flag_q,
               bus_activity_flag_q, frame_start_irq_enable_q,
               frame_end_point_irq_enable_q, packet_end_irq_enable_q,
               bus_activity_irq_enable_q};
            OFS_TIMING_STATUS: begin
               s_axi_rdata[B_RST_F] <= bus_reset_flag_q;
               s_axi_rdata[B_LOCK_F] <= frame_lock_flag_q;
            end
            OFS_HUB_ADDR:
               s_axi_rdata[7:0] <= {module_enable_q, hub_function_addr_q};
            OFS_EP0_IRQ: begin
               s_axi_rdata[B_TX_F] <= ep0_tx_done_flag_q;
               s_axi_rdata[B_RX_F] <= ep0_rx_done_flag_q;
               s_axi_rdata[B_TX_IE] <= ep0_tx_irq_enable_q;
               s_axi_rdata[B_RX_IE] <= ep0_rx_irq_enable_q;
            end
            OFS_EP0_CTRL: s_axi_rdata[7:0] <= {ep0_tx_data_toggle_q,
               ep0_force_stall_q, ep0_tx_enable_q, ep0_rx_enable_q,
               ep0_tx_size_q};
            default: s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- timing flags ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_start_flag_q <= 1'b0;
         frame_end_point_flag_q <= 1'b0;
         packet_end_flag_q <= 1'b0;
         bus_activity_flag_q <= 1'b0;
      end else begin
         frame_start_flag_q <= flag_next(frame_start_flag_q, sof_seen,
            wr_ts && wbyte[B_SOF_CLR]);
         frame_end_point_flag_q <= flag_next(frame_end_point_flag_q,
            frame_end_point_pulse, wr_ts && wbyte[B_FRAME_END_POINT_CLR]);
         packet_end_flag_q <= flag_next(packet_end_flag_q, eop_pulse,
            wr_ts && wbyte[B_EOP_CLR]);
         bus_activity_flag_q <= flag_next(bus_activity_flag_q,
            transition_pulse, wr_ts && wbyte[B_TRAN_CLR]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_start_irq_enable_q <= 1'b0;
         frame_end_point_irq_enable_q <= 1'b0;
         packet_end_irq_enable_q <= 1'b0;
         bus_activity_irq_enable_q <= 1'b0;
      end else if (wr_ti) begin
         frame_start_irq_enable_q <= wbyte[B_SOF_IE];
         frame_end_point_irq_enable_q <= wbyte[B_FRAME_END_POINT_IE];
         packet_end_irq_enable_q <= wbyte[B_EOP_IE];
         bus_activity_irq_enable_q <= wbyte[B_TRAN_IE];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_lock_flag_q <= 1'b0;
      end else begin
         frame_lock_flag_q <= flag_next(frame_lock_flag_q, lock_pulse,
            wr_ts && wbyte[B_LOCK_CLR]);
      end
   end

   // survives the reset it causes, so software can tell why it restarted
   always_ff @(posedge aclk) begin
      if (!por_n) begin
         bus_reset_flag_q <= 1'b0;
      end else begin
         bus_reset_flag_q <= flag_next(bus_reset_flag_q, bus_reset_pulse,
            wr_ts && wbyte[B_RST_CLR]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_reset_req <= 1'b0;
      end else begin
         bus_reset_req <= bus_reset_pulse;
      end
   end

   // ---------------- enable and address ----------------
   always_ff @(posedge aclk) begin
      if (!por_n) begin
         module_enable_q <= 1'b0;
      end else if (wr_ha && wbyte[B_MOD_EN]) begin
         module_enable_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hub_function_addr_q <= '0;
      end else if (wr_ha) begin
         hub_function_addr_q <= wbyte[ADDR_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!por_n) begin
         regulated_supply_output <= 1'b0;
         transceiver_enable <= 1'b0;
      end else begin
         regulated_supply_output <= module_enable_q;
         transceiver_enable <= module_enable_q;
      end
   end

   // ---------------- endpoint 0 control ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ep0_tx_irq_enable_q <= 1'b0;
         ep0_rx_irq_enable_q <= 1'b0;
      end else if (wr_ei) begin
         ep0_tx_irq_enable_q <= wbyte[B_TX_IE];
         ep0_rx_irq_enable_q <= wbyte[B_RX_IE];
      end
   end

   // toggle is written by software only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ep0_tx_data_toggle_q <= 1'b0;
         ep0_tx_enable_q <= 1'b0;
         ep0_rx_enable_q <= 1'b0;
         ep0_tx_size_q <= '0;
      end else if (wr_ec) begin
         ep0_tx_data_toggle_q <= wbyte[B_EP0_TX_DATA_TOGGLE];
         ep0_tx_enable_q <= wbyte[B_TXE];
         ep0_rx_enable_q <= wbyte[B_RXE];
         ep0_tx_size_q <= wbyte[TSIZE_W-1:0];
      end
   end

   // a SETUP must always get through, so it overrides a software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ep0_force_stall_q <= 1'b0;
      end else if (tok_ep0 && tok_pid == PID_SETUP) begin
         ep0_force_stall_q <= 1'b0;
      end else if (wr_ec) begin
         ep0_force_stall_q <= wbyte[B_STALL];
      end
   end

   // transaction sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
         hs_valid <= 1'b0;
         hs_code <= HS_NAK;
         hs_tx_size <= '0;
      end else begin
         hs_valid <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (tok_ep0) begin
                  unique case (tok_pid)
                     PID_IN: begin
                        hs_valid <= 1'b1;
                        if (ep0_force_stall_q) begin
                           hs_code <= HS_STALL;
                        end else if (!ep0_tx_enable_q
                                     || ep0_tx_done_flag_q) begin
                           hs_code <= HS_NAK;
                        end else begin
                           hs_code <= ep0_tx_data_toggle_q
                              ? HS_DATA1 : HS_DATA0;
                           hs_tx_size <= ep0_tx_size_q;
                           state_q <= ST_WAIT_ACK;
                        end
                     end
                     PID_OUT: begin
                        if (ep0_force_stall_q) begin
                           hs_valid <= 1'b1;
                           hs_code <= HS_STALL;
                        end else if (!ep0_rx_enable_q
                                     || ep0_rx_done_flag_q) begin
                           hs_valid <= 1'b1;
                           hs_code <= HS_NAK;
                        end else begin
                           state_q <= ST_WAIT_DATA;
                        end
                     end
                     PID_SETUP: state_q <= ST_WAIT_DATA;
                     PID_SOF: state_q <= ST_IDLE;
                  endcase
               end
            end
            // a fresh token means the previous transaction was abandoned
            ST_WAIT_ACK: begin
               if (host_ack || tok_live) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_WAIT_DATA: begin
               if (rx_data_ok) begin
                  hs_valid <= 1'b1;
                  hs_code <= HS_ACK;
                  state_q <= ST_IDLE;
               end else if (tok_live) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ep0_tx_done_flag_q <= 1'b0;
         ep0_rx_done_flag_q <= 1'b0;
      end else begin
         ep0_tx_done_flag_q <= flag_next(ep0_tx_done_flag_q,
            state_q == ST_WAIT_ACK && host_ack,
            wr_ei && wbyte[B_TX_CLR]);
         ep0_rx_done_flag_q <= flag_next(ep0_rx_done_flag_q,
            state_q == ST_WAIT_DATA && rx_data_ok,
            wr_ei && wbyte[B_RX_CLR]);
      end
   end

   // level request, drops when software clears or masks the flags, or on aresetn
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= (frame_start_flag_q && frame_start_irq_enable_q)
            || (frame_end_point_flag_q && frame_end_point_irq_enable_q)
            || (packet_end_flag_q && packet_end_irq_enable_q)
            || (bus_activity_flag_q && bus_activity_irq_enable_q)
            || (ep0_tx_done_flag_q && ep0_tx_irq_enable_q)
            || (ep0_rx_done_flag_q && ep0_rx_irq_enable_q);
      end
   end
endmodule
`default_nettype wire

//--- usbsie_core_properties.sv
`default_nettype none
module usbsie_core_properties (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // token side
   input wire logic tok_valid,
   input wire logic rx_data_ok,
   input wire logic hs_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_axi_awready && s_axi_wready;
   endsequence
   a_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
      else $error("aw and w ready differ");
   a_write_resp: assert property (s_wr_taken |=> s_axi_bvalid)
      else $error("no write response");
   a_read_resp: assert property (s_axi_arready |=> s_axi_rvalid)
      else $error("no read response");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("bvalid dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid) else $error("rvalid dropped");
   a_no_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while busy");
   a_no_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_hs_cause: assert property (hs_valid |->
      $past(tok_valid) || $past(rx_data_ok)) else $error("stray hs");
endmodule
`default_nettype wire

//--- usbsie_host_model.sv
`default_nettype none
module usbsie_host_model import usbsie_pkg::*; (
   // clock
   input wire logic aclk,
   // token and packet events
   output logic tok_valid,
   output usbsie_pid_type tok_pid,
   output logic [6:0] tok_addr,
   output logic rx_data_ok,
   output logic host_ack,
   // answer from the hub
   input wire logic hs_valid,
   input wire usbsie_hs_type hs_code
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      tok_valid = 1'b0;
      tok_pid = PID_SOF;
      tok_addr = 7'h00;
      rx_data_ok = 1'b0;
      host_ack = 1'b0;
   end
   // host acks every data packet it gets
   always @(posedge aclk) begin
      host_ack <= hs_valid && (hs_code inside {HS_DATA0, HS_DATA1});
   end
   task automatic send(input usbsie_pid_type p, input logic [6:0] a);
      tok_valid <= 1'b1;
      tok_pid <= p;
      tok_addr <= a;
      @(posedge aclk);
      tok_valid <= 1'b0;
      // data stage after every token but IN, so SOF too
      rx_data_ok <= (p != PID_IN);
      @(posedge aclk);
      rx_data_ok <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
endmodule
`default_nettype wire

//--- usbsie_core_tb.sv
`default_nettype none
module usbsie_core_tb import usbsie_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, por_n = 0, root_dp = 1, root_dm = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic s_axi_bready = 1, s_axi_rready = 1, rst_seen = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, tok_valid, rx_data_ok, host_ack, hs_valid, irq;
   logic bus_reset_req, regulated_supply_output, transceiver_enable;
   logic [6:0] tok_addr;
   logic [3:0] hs_tx_size;
   usbsie_pid_type tok_pid;
   usbsie_hs_type hs_code;
   int mismatches = 0, comparisons = 0, cyc = 0;
   usbsie_core #(.FRAME_LEN(200), .RESET_LEN(8)) u_dut (.*,
      .s_axi_wstrb(4'hF), .tok_endp(4'h0), .downstream_activity(1'b0));
   usbsie_host_model u_host (.*);
   always #5 aclk = ~aclk;
   always @(posedge aclk) if (bus_reset_req) rst_seen <= 1'b1;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_awready);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_bvalid);
   endtask
   task automatic rd(input logic [7:0] a, m, e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      check("rdata", s_axi_rdata & {24'h0, m}, {24'h0, e});
      check("rresp", s_axi_rresp, a > 8'h10 ? RESP_SLVERR : RESP_OKAY);
   endtask
   task automatic tok(input usbsie_pid_type p, input logic [6:0] a,
      input usbsie_hs_type e);
      u_host.send(p, a);
      check("hs_code", hs_code, e);
   endtask
   task automatic irq_is(input logic e);
      @(posedge aclk);
      check("irq", irq, e);
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge aclk);
      check("supply", regulated_supply_output, 1'b0);
      rd(OFS_TIMING_IRQ, 8'hF0, 8'h00);
      rd(OFS_HUB_ADDR, 8'hFF, 8'h00);
      rd(8'h20, 8'hFF, 8'h00);
      tok(PID_SETUP, 7'h00, HS_NAK);
      wr(OFS_HUB_ADDR, 8'h85);
      wr(OFS_HUB_ADDR, 8'h05);
      rd(OFS_HUB_ADDR, 8'hFF, 8'h85);
      check("pwr", {regulated_supply_output, transceiver_enable}, 2'h3);
      tok(PID_IN, 7'h05, HS_NAK);
      wr(OFS_EP0_CTRL, 8'hA3);
      tok(PID_IN, 7'h05, HS_DATA1);
      check("size", hs_tx_size, 4'h3);
      rd(OFS_EP0_IRQ, 8'hFF, 8'h80);
      tok(PID_IN, 7'h06, HS_DATA1);
      tok(PID_IN, 7'h05, HS_NAK);
      rd(OFS_EP0_CTRL, 8'hFF, 8'hA3);
      wr(OFS_EP0_IRQ, 8'h08);
      irq_is(1'b1);
      wr(OFS_EP0_IRQ, 8'h0A);
      irq_is(1'b0);
      rd(OFS_EP0_IRQ, 8'hFF, 8'h08);
      wr(OFS_EP0_CTRL, 8'h50);
      tok(PID_OUT, 7'h05, HS_STALL);
      tok(PID_SETUP, 7'h05, HS_ACK);
      rd(OFS_EP0_CTRL, 8'hFF, 8'h10);
      rd(OFS_EP0_IRQ, 8'hC0, 8'h40);
      tok(PID_OUT, 7'h05, HS_NAK);
      u_host.send(PID_SOF, 7'h00);
      rd(OFS_TIMING_IRQ, 8'h80, 8'h80);
      root_dp <= 1'b0;
      repeat (12) @(posedge aclk);
      root_dp <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(OFS_TIMING_IRQ, 8'h30, 8'h30);
      wr(OFS_TIMING_IRQ, 8'h02);
      irq_is(1'b1);
      wr(OFS_TIMING_STATUS, 8'h02);
      irq_is(1'b0);
      rd(OFS_TIMING_STATUS, 8'h80, 8'h80);
      check("rst_req", rst_seen, 1'b1);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_TIMING_STATUS, 8'h80, 8'h80);
      rd(OFS_HUB_ADDR, 8'hFF, 8'h80);
      wr(OFS_TIMING_STATUS, 8'h40);
      rd(OFS_TIMING_STATUS, 8'hC0, 8'h00);
      complete_run();
   end
endmodule
bind usbsie_core usbsie_core_properties u_chk (.*);
`default_nettype wire
